/* File: design/pixel_out_pkg.sv */
// Overview of operation
// - Frame-sync duplication bit set drives the row strobe exactly like frame strobe.
// - Status insertion appends the status byte after the last compressed byte.
// - Spoof codes bit inserts SOF, EOF, SOL, EOL markers into uncompressed spoof frames.
// - Shadow hold bit blocks copying of configuration into the shadow set.
// - Shadow set loads at end of input vertical blanking when hold is clear.
// - Source one ticks at master clock divided by divisor_one, reset 1.
// - Source two ticks at master clock divided by divisor_two, reset 5.
// - Source three ticks at master clock divided by divisor_three, reset 3.
// - A divisor of zero behaves exactly like a divisor of one.
// - Variable rate moves source one to source two at half fullness.
// - Variable rate moves source two to source three at three-quarter fullness.
// - Slew output follows the slew field of the selected clock source.
// - Each spoof row carries exactly the spoof width count of data bytes; a count of zero gives 4096.
// - Falls back below half and below quarter; every frame starts on source one.
// - Spoof mode sends buffered data as synthetic frame of rows and gaps.
package pixel_out_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_OUT_CFG = 8'h0D;
  localparam logic [7:0] OFS_CLK_ONE_TWO = 8'h0E;
  localparam logic [7:0] OFS_CLK_THREE = 8'h0F;
  localparam logic [7:0] OFS_SPOOF_WIDTH = 8'h10;

  // ==========================================================
  // Reset values
  localparam logic [11:0] RST_OUT_CFG = 12'h007;
  localparam logic [15:0] RST_CLK_ONE_TWO = 16'h0501;
  localparam logic [7:0] RST_CLK_THREE = 8'h03;
  localparam logic [11:0] RST_SPOOF_WIDTH = 12'h640;

  // ==========================================================
  // Field positions in the output configuration register
  localparam int CFG_SPOOF = 0;
  localparam int CFG_CLK_IDLE = 1;
  localparam int CFG_VAR_RATE = 6;
  localparam int CFG_DUP_STROBE = 8;
  localparam int CFG_STATUS = 9;
  localparam int CFG_CODES = 10;
  localparam int CFG_HOLD = 11;

  // ==========================================================
  // Markers, padding and row gaps in output clock ticks
  localparam logic [31:0] CODE_SOF = 32'hFF0000AB;
  localparam logic [31:0] CODE_EOF = 32'hFF0000B6;
  localparam logic [31:0] CODE_SOL = 32'hFF00009D;
  localparam logic [31:0] CODE_EOL_DEFAULT = 32'hFF000080;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [7:0] ROW_LEAD = 8'h06;
  localparam logic [7:0] ROW_TRAIL = 8'h06;

  typedef enum {SRC_ONE, SRC_TWO, SRC_THREE} clk_src_t;
  typedef enum {ST_IDLE, ST_LEAD, ST_MARK, ST_ROW, ST_TRAIL} frame_state_t;

  // Shadow copy of everything the output stage uses during a frame
  typedef struct packed {
    logic [11:0] outCfg;
    logic [15:0] clkOneTwo;
    logic [7:0] clkThree;
    logic [11:0] spoofWidth;
  } shadow_t;

endpackage

/* File: design/clk_divider.sv */
module clk_divider (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic restart,
  input wire logic [3:0] divisor,
  output logic tick
);
  logic [3:0] count;
  logic [3:0] lastCount;

  // ==========================================================
  // Divide by divisor, zero acting as one
  assign lastCount = (divisor == 4'h0) ? 4'h0 : divisor - 4'h1;
  // A divisor cut below the running count ticks at once instead of wrapping
  assign tick = (count >= lastCount);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 4'h0;
    end else if (restart || tick) begin
      count <= 4'h0;
    end else begin
      count <= count + 4'h1;
    end
  end
endmodule

/* File: design/image_output_clock_and_framing.sv */
module image_output_clock_and_framing #(
  parameter int FIFO_DEPTH = 1024,
  parameter int LEVEL_W = 11,
  parameter logic [31:0] CODE_EOL = pixel_out_pkg::CODE_EOL_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  input wire logic vblankEnd,
  input wire logic compressedMode,
  input wire logic [7:0] statusByte,
  input wire logic [7:0] fifoData,
  input wire logic fifoValid,
  input wire logic fifoLast,
  input wire logic [LEVEL_W-1:0] fifoLevel,
  output logic fifoRead,
  output logic pixelOutClock,
  output logic [7:0] pixOut,
  output logic frameValid,
  output logic rowValid,
  output logic [2:0] slewRate
);
  import pixel_out_pkg::*;

  localparam logic [LEVEL_W-1:0] LVL_QUARTER = LEVEL_W'(FIFO_DEPTH / 4);
  localparam logic [LEVEL_W-1:0] LVL_HALF = LEVEL_W'(FIFO_DEPTH / 2);
  localparam logic [LEVEL_W-1:0] LVL_THREEQ = LEVEL_W'((FIFO_DEPTH * 3) / 4);

  shadow_t live;
  shadow_t shadow;
  clk_src_t srcSel;
  clk_src_t next_srcSel;
  frame_state_t state;
  logic [2:0] srcTick;
  logic [3:0] divisors [3];
  logic tick;
  logic restart;
  logic frameStart;
  logic spoofOn;
  logic codesOn;
  logic statusOn;
  logic [7:0] gapCount;
  logic [11:0] byteCount;
  logic [1:0] markIdx;
  logic [31:0] markCode;
  frame_state_t afterMark;
  logic firstRow;
  logic streamDone;
  logic statusPending;
  logic rowValidInt;

  // ==========================================================
  // Register file
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      live <= '{RST_OUT_CFG, RST_CLK_ONE_TWO, RST_CLK_THREE, RST_SPOOF_WIDTH};
    end else if (regWrEn) begin
      case (regAddr)
        OFS_OUT_CFG: live.outCfg <= regWrData[11:0];
        OFS_CLK_ONE_TWO: live.clkOneTwo <= regWrData;
        OFS_CLK_THREE: live.clkThree <= regWrData[7:0];
        OFS_SPOOF_WIDTH: live.spoofWidth <= regWrData[11:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 16'h0000;
    end else begin
      case (regAddr)
        OFS_OUT_CFG: regRdData <= {4'h0, live.outCfg};
        OFS_CLK_ONE_TWO: regRdData <= live.clkOneTwo;
        OFS_CLK_THREE: regRdData <= {8'h00, live.clkThree};
        OFS_SPOOF_WIDTH: regRdData <= {4'h0, live.spoofWidth};
        default: regRdData <= 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // Shadow set; the hold bit itself always acts live
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shadow <= '{RST_OUT_CFG, RST_CLK_ONE_TWO, RST_CLK_THREE, RST_SPOOF_WIDTH};
    end else if (vblankEnd && !live.outCfg[CFG_HOLD]) begin
      shadow <= live;
    end
  end

  assign spoofOn = shadow.outCfg[CFG_SPOOF];
  assign codesOn = shadow.outCfg[CFG_CODES] && spoofOn && !compressedMode;
  assign statusOn = shadow.outCfg[CFG_STATUS] && compressedMode;

  // ==========================================================
  // Three clock sources
  assign divisors[0] = shadow.clkOneTwo[3:0];
  assign divisors[1] = shadow.clkOneTwo[11:8];
  assign divisors[2] = shadow.clkThree[3:0];

  for (genvar i = 0; i < 3; i++) begin : g_src
    clk_divider u_div (
      .mclk(mclk),
      .rst_b(rst_b),
      .restart(restart),
      .divisor(divisors[i]),
      .tick(srcTick[i])
    );
  end

  assign tick = srcTick[srcSel];
  assign frameStart = tick && (state == ST_IDLE) && fifoValid && !frameValid;

  // Switching only on a tick of the current source and restarting every
  // divider means no output period is ever cut short
  always_comb begin
    next_srcSel = srcSel;
    if (frameStart || !shadow.outCfg[CFG_VAR_RATE]) begin
      next_srcSel = SRC_ONE;
    end else begin
      case (srcSel)
        SRC_ONE: if (fifoLevel >= LVL_HALF) next_srcSel = SRC_TWO;
        SRC_TWO: begin
          if (fifoLevel >= LVL_THREEQ) begin
            next_srcSel = SRC_THREE;
          end else if (fifoLevel < LVL_QUARTER) begin
            next_srcSel = SRC_ONE;
          end
        end
        SRC_THREE: if (fifoLevel < LVL_HALF) next_srcSel = SRC_TWO;
        default: next_srcSel = SRC_ONE;
      endcase
    end
  end

  assign restart = tick && (next_srcSel != srcSel);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      srcSel <= SRC_ONE;
    end else if (tick) begin
      srcSel <= next_srcSel;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      slewRate <= 3'h0;
    end else begin
      case (srcSel)
        SRC_ONE: slewRate <= shadow.clkOneTwo[7:5];
        SRC_TWO: slewRate <= shadow.clkOneTwo[15:13];
        SRC_THREE: slewRate <= shadow.clkThree[7:5];
        default: slewRate <= 3'h0;
      endcase
    end
  end

  // Clock pulse registered so it lines up with the byte it marks
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pixelOutClock <= 1'b0;
    end else begin
      pixelOutClock <= tick && (frameValid || shadow.outCfg[CFG_CLK_IDLE]);
    end
  end

  // ==========================================================
  // Frame sequencer
  assign fifoRead = tick && (state == ST_ROW) && fifoValid && !streamDone && !statusPending;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      frameValid <= 1'b0;
      rowValidInt <= 1'b0;
      pixOut <= 8'h00;
      gapCount <= 8'h00;
      byteCount <= 12'h000;
      markIdx <= 2'h0;
      markCode <= 32'h0000_0000;
      afterMark <= ST_IDLE;
      firstRow <= 1'b0;
      streamDone <= 1'b0;
      statusPending <= 1'b0;
    end else if (tick) begin
      case (state)
        ST_IDLE: begin
          // One idle tick with the frame strobe still high keeps the last marker byte inside it
          if (frameValid) begin
            frameValid <= 1'b0;
          end else if (fifoValid) begin
            frameValid <= 1'b1;
            firstRow <= 1'b1;
            streamDone <= 1'b0;
            gapCount <= 8'h00;
            state <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          gapCount <= gapCount + 8'h01;
          if (gapCount == ROW_LEAD - 8'h01) begin
            byteCount <= 12'h000;
            if (codesOn) begin
              markCode <= firstRow ? CODE_SOF : CODE_SOL;
              markIdx <= 2'h0;
              afterMark <= ST_ROW;
              state <= ST_MARK;
            end else begin
              // Row strobe rises with the first row byte, not before it
              state <= ST_ROW;
            end
          end
        end
        ST_MARK: begin
          pixOut <= markCode[31:24];
          markCode <= {markCode[23:0], 8'h00};
          markIdx <= markIdx + 2'h1;
          rowValidInt <= 1'b0;
          if (markIdx == 2'h3) begin
            state <= afterMark;
            gapCount <= 8'h00;
          end
        end
        ST_ROW: begin
          if (statusPending) begin
            pixOut <= statusByte;
            statusPending <= 1'b0;
          end else if (fifoValid && !streamDone) begin
            pixOut <= fifoData;
            if (fifoLast) begin
              streamDone <= 1'b1;
              statusPending <= statusOn;
            end
          end else begin
            pixOut <= PAD_BYTE;
          end
          byteCount <= byteCount + 12'h001;
          // Strobe covers the byte sent on this tick; the pad closing a plain row is outside
          rowValidInt <= spoofOn || !(streamDone && !statusPending);
          // Spoof rows are padded to full width; plain rows end with the stream
          if (spoofOn ? (byteCount == shadow.spoofWidth - 12'h001)
                      : (streamDone && !statusPending)) begin
            firstRow <= 1'b0;
            gapCount <= 8'h00;
            if (codesOn) begin
              markCode <= CODE_EOL;
              markIdx <= 2'h0;
              afterMark <= ST_TRAIL;
              state <= ST_MARK;
            end else begin
              state <= ST_TRAIL;
            end
          end
        end
        ST_TRAIL: begin
          rowValidInt <= 1'b0;
          gapCount <= gapCount + 8'h01;
          if (gapCount == ROW_TRAIL - 8'h01) begin
            gapCount <= 8'h00;
            if (!streamDone || statusPending) begin
              state <= ST_LEAD;
            end else if (codesOn) begin
              markCode <= CODE_EOF;
              markIdx <= 2'h0;
              afterMark <= ST_IDLE;
              state <= ST_MARK;
            end else begin
              frameValid <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign rowValid = shadow.outCfg[CFG_DUP_STROBE] ? frameValid : rowValidInt;
endmodule

/* File: dv/image_output_clock_and_framing_asserts.sv */
module image_output_clock_and_framing_asserts (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic vblankEnd,
  input wire logic compressedMode,
  input wire logic [7:0] statusByte,
  input wire logic [7:0] fifoData,
  input wire logic fifoValid,
  input wire logic fifoLast,
  input wire logic fifoRead,
  input wire logic pixelOutClock,
  input wire logic [7:0] pixOut,
  input wire logic frameValid,
  input wire logic rowValid,
  input wire logic [2:0] slewRate
);
  timeunit 1ns;
  timeprecision 1ns;
  import pixel_out_pkg::*;
  // ==========================================
  // Live and shadow register model
  logic [11:0] liveCfg, shCfg;
  logic [15:0] liveClk, shClk, expRd;
  assign expRd = regAddr == OFS_OUT_CFG ? {4'h0, liveCfg} :
                 regAddr == OFS_CLK_ONE_TWO ? liveClk : 16'h0000;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      liveCfg <= RST_OUT_CFG;
      liveClk <= RST_CLK_ONE_TWO;
    end else if (regWrEn && regAddr == OFS_OUT_CFG) begin
      liveCfg <= regWrData[11:0];
    end else if (regWrEn && regAddr == OFS_CLK_ONE_TWO) begin
      liveClk <= regWrData;
    end
  end
  // Hold is read live, so it can always be released again
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shCfg <= RST_OUT_CFG;
      shClk <= RST_CLK_ONE_TWO;
    end else if (vblankEnd && !liveCfg[CFG_HOLD]) begin
      shCfg <= liveCfg;
      shClk <= liveClk;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // ==========================================
  // Assertions
  property p_dup; shCfg[CFG_DUP_STROBE] |-> rowValid == frameValid; endproperty
  a_dup: assert property (p_dup) else $error("row strobe not a copy");
  property p_guard; fifoRead |-> fifoValid && frameValid; endproperty
  a_guard: assert property (p_guard) else $error("pop outside a frame");
  property p_out; fifoRead |=> pixelOutClock && pixOut == $past(fifoData); endproperty
  a_out: assert property (p_out) else $error("popped byte not sent");
  property p_last; fifoRead && fifoLast |=> !fifoRead [*6]; endproperty
  a_last: assert property (p_last) else $error("pop after last byte");
  property p_status;
    fifoRead && fifoLast && shCfg[CFG_STATUS] && compressedMode
      |=> ##[1:16] (pixelOutClock && pixOut == statusByte);
  endproperty
  a_status: assert property (p_status) else $error("status byte missing");
  property p_regrd;
    !regWrEn && (regAddr < OFS_CLK_THREE || regAddr > OFS_SPOOF_WIDTH)
      |=> regRdData == $past(expRd);
  endproperty
  a_regrd: assert property (p_regrd) else $error("register read wrong");
  // Fixed rate shows the slew of source one from 20 master clocks after a load onward
  logic [4:0] calm;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      calm <= 5'h00;
    end else if (vblankEnd || shCfg[CFG_VAR_RATE]) begin
      calm <= 5'h00;
    end else if (calm != 5'h1F) begin
      calm <= calm + 5'h01;
    end
  end
  property p_slew;
    calm >= 5'h14 |-> slewRate == shClk[7:5];
  endproperty
  a_slew: assert property (p_slew) else $error("slew not of source one");
  property p_idle; !frameValid |-> !rowValid; endproperty
  a_idle: assert property (p_idle) else $error("row strobe outside frame");
endmodule

bind image_output_clock_and_framing image_output_clock_and_framing_asserts chk (.mclk, .rst_b,
  .regWrEn, .regAddr, .regWrData, .regRdData, .vblankEnd, .compressedMode, .statusByte,
  .fifoData, .fifoValid, .fifoLast, .fifoRead, .pixelOutClock, .pixOut, .frameValid, .rowValid,
  .slewRate);

/* File: dv/host_receiver.sv */
module host_receiver (
  input wire logic mclk,
  input wire logic pixelOutClock,
  input wire logic [7:0] pixOut,
  input wire logic frameValid,
  input wire logic rowValid
);
  timeunit 1ns;
  timeprecision 1ns;
  import pixel_out_pkg::*;
  // ==========================================
  // Capture bytes per byte period, spot markers, measure rows
  logic [31:0] recent = 0;
  logic [7:0] rowBytes[$];
  int rowCount = 0;
  int lastRowLen = 0;
  logic rowWas = 0, sawSof = 0, sawSol = 0, sawEol = 0, sawEof = 0;
  always @(posedge mclk) begin
    rowWas <= rowValid;
    if (pixelOutClock && frameValid) recent <= {recent[23:0], pixOut};
    if (pixelOutClock && rowValid) rowBytes.push_back(pixOut);
    if (pixelOutClock && rowValid) rowCount <= rowCount + 1;
    if (rowWas && !rowValid) lastRowLen <= rowCount;
    if (rowWas && !rowValid) rowCount <= 0;
    if (recent == CODE_SOF) sawSof <= 1;
    if (recent == CODE_SOL) sawSol <= 1;
    if (recent == CODE_EOL_DEFAULT) sawEol <= 1;
    if (recent == CODE_EOF) sawEof <= 1;
  end
endmodule

/* File: dv/image_output_clock_and_framing_tb_top.sv */
module image_output_clock_and_framing_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pixel_out_pkg::*;
  logic mclk = 0, rst_b = 0, regWrEn = 0, vblankEnd = 0, compressedMode = 0;
  logic fifoValid = 0, fifoLast = 0, fifoRead, pixelOutClock, frameValid, rowValid;
  logic [7:0] regAddr = 0, statusByte = 0, fifoData = 0, pixOut;
  logic [15:0] regWrData = 0, regRdData;
  logic [10:0] fifoLevel = 0;
  logic [2:0] slewRate;
  logic [7:0] mem [256];
  logic [3:0] dv [4] = '{4'h0, 4'h3, 4'h9, 4'h1};
  int lv [6] = '{511, 512, 768, 600, 511, 255}, gv [6] = '{2, 5, 4, 4, 5, 2};
  int seed = 32'h9ff6a73d, miscompares = 0, comparisons = 0, popCnt = 0, nBytes = 0, n, i;
  image_output_clock_and_framing uut (.mclk, .rst_b, .regWrEn, .regAddr, .regWrData,
    .regRdData, .vblankEnd, .compressedMode, .statusByte, .fifoData, .fifoValid, .fifoLast,
    .fifoLevel, .fifoRead, .pixelOutClock, .pixOut, .frameValid, .rowValid, .slewRate);
  host_receiver host (.mclk, .pixelOutClock, .pixOut, .frameValid, .rowValid);
  always #50 mclk = ~mclk;
  // ==========================================
  // Output buffer stand-in: head byte follows the pop count
  always @(posedge mclk) if (fifoRead) popCnt <= popCnt + 1;
  always @(negedge mclk) begin
    fifoValid = popCnt < nBytes;
    fifoLast = popCnt == nBytes - 1;
    fifoData = mem[popCnt[7:0]];
  end
  // ==========================================
  // Tasks
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(negedge mclk);
    {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
    @(negedge mclk);
    regWrEn = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] e);
    @(negedge mclk);
    regAddr = a;
    @(negedge mclk);
    check("reg", e, regRdData);
  endtask
  task automatic load();
    @(negedge mclk);
    vblankEnd = 1;
    @(negedge mclk);
    vblankEnd = 0;
  endtask
  // Period of the output clock in master clocks, seen at settled falling edges
  task automatic gap(output int g);
    g = 0;
    do begin
      @(negedge mclk);
      g++;
    end while (pixelOutClock !== 1'b1 && g < 300);
    if (g == 300) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic start(int cnt);
    int k;
    popCnt = 0;
    host.rowBytes.delete();
    {host.sawSof, host.sawSol, host.sawEol, host.sawEof} = 4'h0;
    for (k = 0; k < 256; k++) mem[k] = $random(seed);
    statusByte = $random(seed);
    nBytes = cnt;
  endtask
  task automatic drain();
    int k;
    for (k = 0; k < 20000 && (popCnt < nBytes || frameValid !== 1'b0); k++) @(negedge mclk);
    if (k == 20000) begin
      miscompares++;
      close_out();
    end
    repeat (3) @(negedge mclk);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(negedge mclk);
    rst_b = 1;
    rd(OFS_OUT_CFG, 16'h0007);
    rd(OFS_CLK_ONE_TWO, 16'h0501);
    rd(OFS_CLK_THREE, 16'h0003);
    rd(OFS_SPOOF_WIDTH, 16'h0640);
    rd(8'h11, 16'h0000);
    for (i = 0; i < 4; i++) begin
      n = $random(seed);
      wr(OFS_SPOOF_WIDTH, {n[15:1], 1'b0});
      rd(OFS_SPOOF_WIDTH, {4'h0, n[11:1], 1'b0});
      wr(OFS_CLK_THREE, n[15:0]);
      rd(OFS_CLK_THREE, {8'h00, n[7:0]});
    end
    foreach (dv[i]) begin
      wr(OFS_CLK_ONE_TWO, {8'h05, 3'(i), 1'b0, dv[i]});
      load();
      gap(n);
      gap(n);
      check("gap", (dv[i] == 4'h0) ? 1 : dv[i], n);
      check("slew", i, slewRate);
    end
    // Status byte needs a compressed stream; this test sends a continuous one
    wr(OFS_OUT_CFG, 16'h0202);
    compressedMode = 1;
    load();
    start(20);
    drain();
    for (i = 0; i < 20; i++) check("byte", mem[i], host.rowBytes[i]);
    check("status", statusByte, host.rowBytes[20]);
    wr(OFS_SPOOF_WIDTH, 16'h0006);
    wr(OFS_OUT_CFG, 16'h0403);
    compressedMode = 0;
    load();
    start(10);
    drain();
    for (i = 0; i < 12; i++) check("spoof", i < 10 ? mem[i] : PAD_BYTE, host.rowBytes[i]);
    check("markers", 4'hF, {host.sawSof, host.sawSol, host.sawEol, host.sawEof});
    check("rowlen", 6, host.lastRowLen);
    // Held shadows keep spoof codes although the live value drops them
    wr(OFS_OUT_CFG, 16'h0800);
    wr(OFS_OUT_CFG, 16'h0900);
    load();
    start(4);
    drain();
    check("held", 1, host.sawSof);
    wr(OFS_OUT_CFG, 16'h0142);
    wr(OFS_CLK_ONE_TWO, 16'h4522);
    wr(OFS_CLK_THREE, 16'h0064);
    compressedMode = 1;
    load();
    start(200);
    foreach (lv[i]) begin
      fifoLevel = 11'(lv[i]);
      repeat (3) gap(n);
      check("vargap", gv[i], n);
      check("varslew", gv[i] == 2 ? 1 : gv[i] == 5 ? 2 : 3, slewRate);
    end
    fifoLevel = 0;
    drain();
    close_out();
  end
endmodule
